// >>> common/scs_pkg.sv
package scs_pkg;
  // register select codes, address bits 2-0
  localparam logic [2:0] SEL_CTRL_ONE = 3'h0;
  localparam logic [2:0] SEL_CTRL_TWO = 3'h2;
  localparam logic [2:0] SEL_STATUS = 3'h4;
  localparam logic [2:0] SEL_CHAR_PAIR = 3'h4;
  localparam logic [2:0] SEL_BUFFER = 3'h6;
  // address field positions
  localparam int ID_LSB = 3;
  localparam int ID_W = 5;
  localparam int ADDR_W = 8;
  // line_status bit positions
  localparam int ST_MODEM_CHG = 7;
  localparam int ST_SET_READY = 6;
  localparam int ST_CARRIER = 5;
  localparam int ST_SYNC_FRAME = 4;
  localparam int ST_ESC_PARITY = 3;
  localparam int ST_OVERRUN = 2;
  localparam int ST_RX_FULL = 1;
  localparam int ST_TX_EMPTY = 0;
  // acknowledge vector: bit 2 marks a non-transmit cause
  localparam int ACK_CAUSE_BIT = 2;
  // control bits steering this block
  localparam int C1_TERM_READY = 0;
  localparam int C1_TX_EN = 1;
  localparam int C1_RX_EN = 2;
  localparam int C1_PARITY_EN = 3;
  localparam int C1_ESC_STRIP = 4;
  localparam int C2_SYNC_MODE = 5;
  localparam int C2_STRIP_SEL = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CHAR_RESET = 8'h00;
  // host strobe phase length in clocks (250 ns spacing at 100 ns)
  localparam int PHASE_NS = 250;
  localparam int CLK_NS = 100;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
endpackage

// >>> common/scs_bus_if.sv
`timescale 1ns/1ps
interface scs_bus_if;
  logic [7:0] dal_h;
  logic dal_h_oe;
  logic [7:0] dal_d;
  logic [7:0] dal_d_oe;
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic ack_chain_in_n;
  logic ack_chain_out_n;
  logic select_ack_n;
  logic irq_out_n;
  // resolved wire level, undriven bits read high
  logic [7:0] data_access_lines;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dal_d_oe[i]) begin
        data_access_lines[i] = dal_d[i];
      end else if (dal_h_oe) begin
        data_access_lines[i] = dal_h[i];
      end else begin
        data_access_lines[i] = 1'b1;
      end
    end
  end
  modport host (
    output dal_h, dal_h_oe, chip_select_n, read_strobe_n, write_strobe_n,
    output ack_chain_in_n,
    input data_access_lines, select_ack_n, irq_out_n
  );
  modport dev (
    output dal_d, dal_d_oe, ack_chain_out_n, select_ack_n, irq_out_n,
    input data_access_lines, chip_select_n, read_strobe_n,
    input write_strobe_n, ack_chain_in_n
  );
endinterface

// >>> rtl/scs_device.sv
`timescale 1ns/1ps
module scs_device #(
  parameter logic [4:0] ID_CODE = 5'h0a, // arbitrary
  parameter bit FLAG_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host bus
  scs_bus_if.dev bus,
  // modem lines, inputs active low as on the pins, terminal_ready active high
  input wire logic set_ready_in,
  input wire logic carrier_in,
  input wire logic ring_detect_in,
  output logic terminal_ready,
  // receiver engine
  input wire logic rx_load,
  input wire logic [7:0] rx_shift,
  input wire logic rx_stop_bit,
  input wire logic rx_parity_err,
  // transmitter engine
  input wire logic tx_move,
  output logic [7:0] tx_buffer,
  output logic tx_pending,
  // control to engines
  output logic [7:0] control_one,
  output logic [7:0] control_two,
  output logic [7:0] idle_match_char,
  output logic [7:0] link_escape_char
);
  initial begin
    if (ID_CODE > 5'h1f) $error("bad id");
  end
  logic cs_q, rd_q, wr_q;
  logic selected, ack_mode, granted, pair_second;
  logic [2:0] reg_sel;
  logic [7:0] rx_holding;
  logic [7:0] line_status;
  logic dsr_q, car_q, ring_q, prev_escape;
  logic int_rx, int_tx, int_modem, tx_en_q;
  logic cs_fall, rd_fall, wr_fall, idle, rx_en, tx_en, sync_mode;
  logic modem_evt, status_read, rx_read, tx_write, pair_write;
  logic any_cause, ack_rd;
  logic [7:0] rd_data, ack_vec;

  assign rx_en = control_one[scs_pkg::C1_RX_EN];
  assign tx_en = control_one[scs_pkg::C1_TX_EN];
  assign sync_mode = control_two[scs_pkg::C2_SYNC_MODE];
  assign cs_fall = cs_q && !bus.chip_select_n;
  assign rd_fall = rd_q && !bus.read_strobe_n;
  assign wr_fall = wr_q && !bus.write_strobe_n;
  assign idle = bus.chip_select_n && bus.read_strobe_n;
  assign status_read = selected && rd_fall && reg_sel == scs_pkg::SEL_STATUS;
  assign rx_read = selected && rd_fall && reg_sel == scs_pkg::SEL_BUFFER;
  assign tx_write = selected && wr_fall && reg_sel == scs_pkg::SEL_BUFFER;
  assign pair_write = selected && wr_fall &&
                      reg_sel == scs_pkg::SEL_CHAR_PAIR;
  assign modem_evt = terminal_ready ?
    (dsr_q != set_ready_in || car_q != carrier_in) :
    (ring_q && !ring_detect_in);
  assign any_cause = int_rx || int_tx || int_modem;
  assign ack_rd = granted && rd_fall;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      dsr_q <= 1'b1;
      car_q <= 1'b1;
      ring_q <= 1'b1;
      tx_en_q <= 1'b0;
    end else begin
      cs_q <= bus.chip_select_n;
      rd_q <= bus.read_strobe_n;
      wr_q <= bus.write_strobe_n;
      dsr_q <= set_ready_in;
      car_q <= carrier_in;
      ring_q <= ring_detect_in;
      tx_en_q <= tx_en;
    end
  end

  // selection and acknowledge chain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selected <= 1'b0;
      ack_mode <= 1'b0;
      granted <= 1'b0;
      reg_sel <= 3'h0;
      bus.select_ack_n <= 1'b1;
      bus.ack_chain_out_n <= 1'b1;
    end else begin
      if (cs_fall && !bus.ack_chain_in_n) begin
        ack_mode <= 1'b1;
        if (!bus.irq_out_n) begin
          granted <= 1'b1;
          bus.select_ack_n <= 1'b0;
        end else begin
          bus.ack_chain_out_n <= 1'b0;
        end
      end else if (cs_fall && bus.data_access_lines[scs_pkg::ID_LSB +:
                   scs_pkg::ID_W] == ID_CODE) begin
        selected <= 1'b1;
        reg_sel <= bus.data_access_lines[2:0];
        bus.select_ack_n <= 1'b0;
      end else if (idle && (selected || granted)) begin
        selected <= 1'b0;
        granted <= 1'b0;
        bus.select_ack_n <= 1'b1;
      end
      if (ack_mode && idle && bus.ack_chain_in_n && !cs_fall) begin
        ack_mode <= 1'b0;
        bus.ack_chain_out_n <= 1'b1;
      end
    end
  end

  // write side registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control_one <= scs_pkg::CTRL_RESET;
      control_two <= scs_pkg::CTRL_RESET;
      idle_match_char <= scs_pkg::CHAR_RESET;
      link_escape_char <= scs_pkg::CHAR_RESET;
      tx_buffer <= 8'h00;
      pair_second <= 1'b0;
    end else begin
      if (selected && wr_fall) begin
        if (reg_sel == scs_pkg::SEL_CTRL_ONE) begin
          control_one <= bus.data_access_lines;
        end else if (reg_sel == scs_pkg::SEL_CTRL_TWO) begin
          control_two <= bus.data_access_lines;
        end else if (reg_sel == scs_pkg::SEL_BUFFER) begin
          tx_buffer <= bus.data_access_lines;
        end
      end
      if (pair_write) begin
        if (pair_second) begin
          link_escape_char <= bus.data_access_lines;
        end else begin
          idle_match_char <= bus.data_access_lines;
        end
        pair_second <= !pair_second;
      end else if (selected && (wr_fall || rd_fall)) begin
        pair_second <= 1'b0;
      end
    end
  end

  assign terminal_ready = control_one[scs_pkg::C1_TERM_READY];

  // receive holding and status flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_holding <= 8'h00;
      line_status <= 8'h00;
      prev_escape <= 1'b0;
      tx_pending <= 1'b0;
    end else begin
      line_status[scs_pkg::ST_SET_READY] <= !set_ready_in;
      line_status[scs_pkg::ST_CARRIER] <= !carrier_in;
      if (modem_evt) begin
        line_status[scs_pkg::ST_MODEM_CHG] <= 1'b1;
      end else if (status_read) begin
        line_status[scs_pkg::ST_MODEM_CHG] <= 1'b0;
      end
      if (!rx_en) begin
        line_status[4:1] <= 4'h0;
        prev_escape <= 1'b0;
      end else begin
        if (rx_load) begin
          rx_holding <= rx_shift;
          line_status[scs_pkg::ST_RX_FULL] <= 1'b1;
          line_status[scs_pkg::ST_OVERRUN] <=
            line_status[scs_pkg::ST_RX_FULL];
          if (sync_mode) begin
            // with strip select the flag follows one character later
            line_status[scs_pkg::ST_SYNC_FRAME] <=
              control_two[scs_pkg::C2_STRIP_SEL] ?
              prev_escape : (rx_shift == idle_match_char);
          end else begin
            line_status[scs_pkg::ST_SYNC_FRAME] <= !rx_stop_bit;
          end
          if (control_one[scs_pkg::C1_ESC_STRIP]) begin
            line_status[scs_pkg::ST_ESC_PARITY] <= prev_escape;
          end else begin
            line_status[scs_pkg::ST_ESC_PARITY] <=
              control_one[scs_pkg::C1_PARITY_EN] && rx_parity_err;
          end
          prev_escape <= control_one[scs_pkg::C1_ESC_STRIP] ?
            (rx_shift == link_escape_char) : (rx_shift == idle_match_char);
        end else begin
          if (rx_read) begin
            line_status[scs_pkg::ST_RX_FULL] <= 1'b0;
          end
          if (status_read && control_one[scs_pkg::C1_ESC_STRIP]) begin
            line_status[scs_pkg::ST_ESC_PARITY] <= 1'b0;
          end
        end
      end
      if (!tx_en) begin
        line_status[scs_pkg::ST_TX_EMPTY] <= 1'b0;
      end else if (tx_move || (tx_en && !tx_en_q && !tx_pending)) begin
        line_status[scs_pkg::ST_TX_EMPTY] <= 1'b1;
      end else if (tx_write) begin
        line_status[scs_pkg::ST_TX_EMPTY] <= 1'b0;
      end
      if (tx_write) begin
        tx_pending <= 1'b1;
      end else if (tx_move) begin
        tx_pending <= 1'b0;
      end
    end
  end

  // interrupt causes latch until acknowledged
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_rx <= 1'b0;
      int_tx <= 1'b0;
      int_modem <= 1'b0;
      bus.irq_out_n <= 1'b1;
    end else begin
      if (rx_load && rx_en) begin
        int_rx <= 1'b1;
      end else if (ack_rd && (int_rx || int_modem) && int_rx) begin
        int_rx <= 1'b0;
      end
      if (tx_en && (tx_move || (!tx_en_q && !tx_pending))) begin
        int_tx <= 1'b1;
      end else if (ack_rd && !int_rx && !int_modem) begin
        int_tx <= 1'b0;
      end
      if (modem_evt) begin
        int_modem <= 1'b1;
      end else if (ack_rd && !int_rx) begin
        int_modem <= 1'b0;
      end
      // stays low until acknowledge read consumes the last cause
      bus.irq_out_n <= !(any_cause || (tx_en && tx_move) ||
                         (rx_load && rx_en) || modem_evt);
    end
  end

  // read data mux
  always_comb begin
    rd_data = 8'h00;
    if (reg_sel == scs_pkg::SEL_CTRL_ONE) begin
      rd_data = control_one;
    end else if (reg_sel == scs_pkg::SEL_CTRL_TWO) begin
      rd_data = control_two;
    end else if (reg_sel == scs_pkg::SEL_STATUS) begin
      rd_data = line_status;
    end else if (reg_sel == scs_pkg::SEL_BUFFER) begin
      rd_data = rx_holding;
    end
    ack_vec = 8'h00;
    ack_vec[scs_pkg::ID_LSB +: scs_pkg::ID_W] = ID_CODE;
    ack_vec[scs_pkg::ACK_CAUSE_BIT] = int_rx || int_modem;
    ack_vec[scs_pkg::ST_RX_FULL] = line_status[scs_pkg::ST_RX_FULL];
    ack_vec[scs_pkg::ST_TX_EMPTY] = line_status[scs_pkg::ST_TX_EMPTY];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus.dal_d <= 8'h00;
      bus.dal_d_oe <= 8'h00;
    end else if (bus.read_strobe_n) begin
      bus.dal_d_oe <= 8'h00;
    end else if (rd_fall && granted) begin
      bus.dal_d <= ack_vec;
      bus.dal_d_oe <= FLAG_VARIANT ? 8'hff : 8'hfc;
    end else if (rd_fall && selected) begin
      bus.dal_d <= rd_data;
      bus.dal_d_oe <= 8'hff;
    end
  end
endmodule

// >>> rtl/scs_host.sv
`timescale 1ns/1ps
module scs_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link
  scs_bus_if.host bus,
  // user command: op 0 read, 1 write, 2 acknowledge
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic irq_seen
);
  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001, HS_ADDR = 5'b00010, HS_STROBE = 5'b00100,
    HS_END = 5'b01000, HS_GAP = 5'b10000
  } scs_hstate_t;
  scs_hstate_t state;
  logic [3:0] cnt;
  logic [1:0] op;
  logic [7:0] wdata;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HS_IDLE;
      cnt <= 4'h0;
      op <= 2'h0;
      wdata <= 8'h00;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      irq_seen <= 1'b0;
      bus.dal_h <= 8'h00;
      bus.dal_h_oe <= 1'b0;
      bus.chip_select_n <= 1'b1;
      bus.read_strobe_n <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.ack_chain_in_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      irq_seen <= !bus.irq_out_n;
      case (state)
        HS_IDLE: begin
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            op <= cmd_op;
            wdata <= cmd_wdata;
            // address bit 0 forced low
            bus.dal_h <= {cmd_addr[7:1], 1'b0};
            bus.dal_h_oe <= cmd_op != 2'h2;
            cnt <= 4'h0;
            state <= HS_ADDR;
          end
        end
        HS_ADDR: begin
          bus.chip_select_n <= 1'b0;
          bus.ack_chain_in_n <= op != 2'h2;
          cnt <= 4'(scs_pkg::PHASE_CYC);
          state <= HS_STROBE;
        end
        HS_STROBE: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            bus.dal_h <= wdata;
            bus.dal_h_oe <= op == 2'h1;
            bus.read_strobe_n <= op == 2'h1;
            bus.write_strobe_n <= op != 2'h1;
            cnt <= 4'(scs_pkg::PHASE_CYC);
            state <= HS_END;
          end
        end
        HS_END: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            rsp_data <= bus.data_access_lines;
            rsp_valid <= op != 2'h1;
            bus.read_strobe_n <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            bus.chip_select_n <= 1'b1;
            bus.ack_chain_in_n <= 1'b1;
            bus.dal_h_oe <= 1'b0;
            cnt <= 4'(scs_pkg::PHASE_CYC);
            state <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            cmd_ready <= 1'b1;
            state <= HS_IDLE;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end
endmodule

// >>> dv/scs_bus_chk.sv
`timescale 1ns/1ps
module scs_bus_chk #(
  parameter logic [4:0] ID_CODE = 5'h0a
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus lines
  input wire logic [7:0] data_access_lines,
  input wire logic [7:0] dal_d_oe,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic ack_chain_in_n,
  input wire logic ack_chain_out_n,
  input wire logic select_ack_n,
  input wire logic irq_out_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_sel_fall;
    $fell(chip_select_n) && ack_chain_in_n;
  endsequence
  sequence s_all_idle;
    (chip_select_n && read_strobe_n && ack_chain_in_n) [*3];
  endsequence
  property p_sel_match;
    s_sel_fall ##0 (data_access_lines[7:3] == ID_CODE)
      |-> ##[1:4] !select_ack_n;
  endproperty
  property p_sel_miss;
    s_sel_fall ##0 (data_access_lines[7:3] != ID_CODE) |-> select_ack_n [*5];
  endproperty
  property p_sel_hold;
    !select_ack_n && !chip_select_n |=> !select_ack_n;
  endproperty
  property p_rd_drive;
    $fell(read_strobe_n) && !select_ack_n |-> ##[1:4] (dal_d_oe[7:2] == 6'h3f);
  endproperty
  property p_rd_release;
    $rose(read_strobe_n) |-> ##[0:3] (dal_d_oe == 8'h00);
  endproperty
  property p_wr_quiet;
    !write_strobe_n |-> dal_d_oe == 8'h00;
  endproperty
  property p_ack_id;
    !ack_chain_in_n && !read_strobe_n && dal_d_oe[7]
      |-> data_access_lines[7:3] == ID_CODE;
  endproperty
  property p_ack_reply;
    $fell(ack_chain_in_n) && !irq_out_n |-> ##[1:4] !select_ack_n;
  endproperty
  property p_irq_hold;
    !irq_out_n && ack_chain_in_n |=> !irq_out_n;
  endproperty
  property p_chain_pass;
    $fell(ack_chain_in_n) && irq_out_n && !chip_select_n
      |-> ##[1:3] !ack_chain_out_n;
  endproperty
  property p_chain_off;
    s_all_idle |-> ack_chain_out_n;
  endproperty
  a_sel_match: assert property (p_sel_match)
    else $error("select reply missing");
  a_sel_miss: assert property (p_sel_miss)
    else $error("reply on foreign id");
  a_sel_hold: assert property (p_sel_hold)
    else $error("reply dropped early");
  a_rd_drive: assert property (p_rd_drive)
    else $error("read data not driven");
  a_rd_release: assert property (p_rd_release)
    else $error("read data kept on bus");
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("bus driven during write");
  a_ack_id: assert property (p_ack_id)
    else $error("wrong id in vector");
  a_ack_reply: assert property (p_ack_reply)
    else $error("no reply to acknowledge");
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped before acknowledge");
  a_chain_pass: assert property (p_chain_pass)
    else $error("grant not passed down chain");
  a_chain_off: assert property (p_chain_off)
    else $error("chain output stuck low");
endmodule

// >>> dv/test_serial_comm_host_status_irq.sv
`timescale 1ns/1ps
module test_serial_comm_host_status_irq;
  // arbitrary identity
  localparam logic [4:0] ID = 5'h13;
  localparam logic [2:0] C1 = scs_pkg::SEL_CTRL_ONE;
  localparam logic [2:0] C2 = scs_pkg::SEL_CTRL_TWO;
  localparam logic [2:0] ST = scs_pkg::SEL_STATUS;
  localparam logic [2:0] CP = scs_pkg::SEL_CHAR_PAIR;
  localparam logic [2:0] BF = scs_pkg::SEL_BUFFER;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, irq_seen, terminal_ready, tx_pending;
  logic [7:0] rsp_data, tx_buffer, control_one, control_two;
  logic [7:0] idle_match_char, link_escape_char, rd;
  logic set_ready_in = 1'b1;
  logic carrier_in = 1'b1;
  logic ring_detect_in = 1'b1;
  logic rx_load = 1'b0;
  logic [7:0] rx_shift = 8'h00;
  logic rx_stop_bit = 1'b1;
  logic rx_parity_err = 1'b0;
  logic tx_move = 1'b0;
  int bad_count = 0;
  int checks = 0;
  always #50 mclk = ~mclk;
  scs_bus_if bus_if ();
  scs_host scs_host_inst (.mclk(mclk), .rst_n(rst_n), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .irq_seen(irq_seen));
  scs_device #(.ID_CODE(ID), .FLAG_VARIANT(1'b1)) scs_device_inst (
    .mclk(mclk), .rst_n(rst_n), .bus(bus_if), .set_ready_in(set_ready_in),
    .carrier_in(carrier_in), .ring_detect_in(ring_detect_in),
    .terminal_ready(terminal_ready), .rx_load(rx_load), .rx_shift(rx_shift),
    .rx_stop_bit(rx_stop_bit), .rx_parity_err(rx_parity_err),
    .tx_move(tx_move), .tx_buffer(tx_buffer), .tx_pending(tx_pending),
    .control_one(control_one), .control_two(control_two),
    .idle_match_char(idle_match_char), .link_escape_char(link_escape_char));
  scs_bus_chk #(.ID_CODE(ID)) scs_bus_chk_inst (.mclk(mclk), .rst_n(rst_n),
    .data_access_lines(bus_if.data_access_lines), .dal_d_oe(bus_if.dal_d_oe),
    .chip_select_n(bus_if.chip_select_n),
    .read_strobe_n(bus_if.read_strobe_n),
    .write_strobe_n(bus_if.write_strobe_n),
    .ack_chain_in_n(bus_if.ack_chain_in_n),
    .ack_chain_out_n(bus_if.ack_chain_out_n),
    .select_ack_n(bus_if.select_ack_n), .irq_out_n(bus_if.irq_out_n));
  task automatic end_of_test();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // one host command, waits for ready to come back
  task automatic op(input logic [1:0] k, input logic [7:0] a,
      input logic [7:0] d);
    int n;
    logic low;
    low = 1'b0;
    cmd_op = k;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    for (n = 0; n < 60 && !(low && cmd_ready); n++) begin
      @(negedge mclk);
      if (!cmd_ready) low = 1'b1;
      if (rsp_valid) rd = rsp_data;
    end
    if (!(low && cmd_ready)) begin
      bad_count++;
      $display("BAD handshake expected 1 seen 0");
      end_of_test();
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    op(2'h1, {ID, s}, d);
  endtask
  task automatic rdc(input logic [2:0] s, input logic [7:0] e, input string w);
    op(2'h0, {ID, s}, 8'h00);
    chk(w, e, rd);
  endtask
  task automatic irq(input logic e);
    tick(4);
    chk("irq", {7'h0, e}, {7'h0, irq_seen});
  endtask
  task automatic ack(input logic [2:0] low3);
    op(2'h2, 8'h00, 8'h00);
    chk("vector", {ID, low3}, rd);
    irq(1'b0);
  endtask
  task automatic rx_char(input logic [7:0] d, input logic sb, input logic pe);
    rx_shift = d;
    rx_stop_bit = sb;
    rx_parity_err = pe;
    rx_load = 1'b1;
    @(negedge mclk);
    rx_load = 1'b0;
  endtask
  task automatic s_regs();
    wr(C2, 8'h18);
    rdc(C2, 8'h18, "ctrl2");
    chk("ctrl2 port", 8'h18, control_two);
    wr(C1, 8'h08);
    op(2'h1, {ID ^ 5'h01, C1}, 8'hff);
    rdc(C1, 8'h08, "ctrl1");
    rdc(ST, 8'h00, "status");
  endtask
  task automatic s_pair();
    wr(CP, 8'h16);
    wr(CP, 8'h10);
    chk("idle", 8'h16, idle_match_char);
    chk("escape", 8'h10, link_escape_char);
    wr(CP, 8'h32);
    rdc(C1, 8'h08, "ctrl1");
    wr(CP, 8'h33);
    chk("idle", 8'h33, idle_match_char);
    chk("escape", 8'h10, link_escape_char);
  endtask
  task automatic s_modem();
    wr(C1, 8'h09);
    carrier_in = 1'b0;
    irq(1'b1);
    rdc(ST, 8'ha0, "status");
    rdc(ST, 8'h20, "status");
    ack(3'b100);
    wr(C1, 8'h08);
    ring_detect_in = 1'b0;
    irq(1'b1);
    rdc(ST, 8'ha0, "status");
    ack(3'b100);
    ring_detect_in = 1'b1;
    carrier_in = 1'b1;
    set_ready_in = 1'b0;
    irq(1'b0);
    rdc(ST, 8'h40, "status");
    set_ready_in = 1'b1;
  endtask
  task automatic s_rx();
    wr(C1, 8'h0c);
    rx_char(8'h3c, 1'b1, 1'b0);
    irq(1'b1);
    rdc(ST, 8'h02, "status");
    rx_char(8'hc3, 1'b1, 1'b1);
    rdc(ST, 8'h0e, "status");
    rdc(BF, 8'hc3, "rx data");
    rdc(ST, 8'h0c, "status");
    rx_char(8'h55, 1'b0, 1'b0);
    rdc(ST, 8'h12, "status");
    ack(3'b110);
    wr(C1, 8'h08);
    rdc(ST, 8'h00, "status");
  endtask
  task automatic s_sync();
    wr(C2, 8'h20);
    wr(C1, 8'h14);
    rx_char(8'h33, 1'b1, 1'b0);
    rdc(ST, 8'h12, "status");
    rdc(BF, 8'h33, "rx data");
    rx_char(8'h10, 1'b1, 1'b0);
    rdc(ST, 8'h02, "status");
    rdc(BF, 8'h10, "rx data");
    rx_char(8'h41, 1'b1, 1'b1);
    rdc(ST, 8'h0a, "status");
    rdc(ST, 8'h02, "status");
    wr(C1, 8'h08);
    rdc(ST, 8'h00, "status");
    wr(C2, 8'h18);
  endtask
  task automatic s_tx();
    wr(C1, 8'h0a);
    irq(1'b1);
    rdc(ST, 8'h01, "status");
    ack(3'b001);
    wr(BF, 8'h96);
    chk("tx data", 8'h96, tx_buffer);
    chk("pending", 8'h01, {7'h0, tx_pending});
    rdc(ST, 8'h00, "status");
    tx_move = 1'b1;
    @(negedge mclk);
    tx_move = 1'b0;
    irq(1'b1);
    rdc(ST, 8'h01, "status");
    ack(3'b001);
    wr(C1, 8'h08);
    rdc(ST, 8'h00, "status");
    op(2'h2, 8'h00, 8'h00);
    chk("idle vector", 8'hff, rd);
  endtask
  initial begin
    tick(3);
    rst_n = 1'b1;
    tick(1);
    s_regs();
    s_pair();
    s_modem();
    s_sync();
    s_rx();
    s_tx();
    end_of_test();
  end
endmodule
